// *** verilog/spi_command_byte_decoder.sv ***
// How it works
// - A frame runs from chip select falling to chip select rising.
// - The first eight bits after chip select falls form the command byte.
// - Command splits into chip address [7:6], index [5:2], operation [1:0].
// - Write data follows on input, read data on output; quick commands stand alone.
// - A status byte shifts out while the command byte shifts in.
// - Command executes only when its chip address equals the hard-wired one.
// - On address mismatch ignore the command and float the output.
// - Writes aimed at a read-only register are not carried out.
// - Every index reads a register; no read address is undefined.
// - Operation type is fixed for the frame until chip select rises.
// - Type 01 static read, 10 incremental write, 11 incremental read, 00 quick.
// - Code 1010 sets conversion mode to 11, starting or restarting conversion.
// - Code 1011 sets conversion mode to 10, standby.
// - Code 1100 sets conversion mode to 00, converter shutdown.
// - Code 1101 clears the primary configuration register, full shutdown.
// - Code 1110 returns every register to its default.
// - Power-on flag reads 1 after full-reset command, 0 after power-on.
// - Converter data register is defaulted only by the full-reset command.
// - Quick commands execute right after the last command bit.
// - Undefined quick-command codes are ignored.
// - After a quick-command byte the output floats until chip select rises.
// - Quick commands are accepted only while their enable bit is 1.
// - Top two status bits are zero; output drives zero when chip select falls.
// - Status interrupt flags clear once the status byte is fully shifted.
// - Chip select rising abandons the frame and resets the interface.
// - Input sampled on clock rise, output changed on clock fall, either idle level.
`timescale 1ns/10ps
module spi_command_byte_decoder #(
    parameter logic [1:0] hardwired_chip_address = spi_cmd_pkg::DEFAULT_CHIP_ADDR
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Configuration
    input wire logic quick_command_enable,
    // Interrupt events, one-cycle pulses
    input wire logic conversion_done_event,
    input wire logic config_checksum_event,
    // Status flags
    output logic conversion_done_flag,
    output logic config_checksum_flag,
    output logic por_flag,
    // Quick-command effects
    output logic conv_mode_wr,
    output logic [1:0] conv_mode_value,
    output logic config_clear,
    output logic full_reset,
    // Register file requests
    output logic read_start,
    output logic read_incremental,
    output logic read_next,
    output logic write_start,
    output logic [3:0] reg_index,
    output logic write_byte_valid,
    output logic [7:0] write_byte,
    input wire logic [7:0] read_byte
);
    wire logic [2:0] pins_sync;
    wire logic cs_s;
    wire logic sck_s;
    wire logic sdi_s;

    pin_sync u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pins_raw({cs_n, sck, sdi}),
        .pins_sync(pins_sync)
    );
    assign {cs_s, sck_s, sdi_s} = pins_sync;

    cmd_fields_if fields ();
    cmd_decode u_cmd_decode (
        .quick_command_enable(quick_command_enable),
        .fields(fields.decoder)
    );

    logic cs_p_q;
    logic sck_p_q;
    spi_cmd_pkg::link_state_e state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_in_q;
    logic [7:0] shift_out_q;
    logic [5:0] status_q;
    logic sdo_q;
    logic oe_q;
    logic dr_q;
    logic crc_q;
    logic por_q;
    logic mode_wr_q;
    logic [1:0] mode_value_q;
    logic cfg_clear_q;
    logic full_reset_q;
    logic rd_start_q;
    logic rd_inc_q;
    logic rd_next_q;
    logic wr_start_q;
    logic [3:0] index_q;
    logic wr_valid_q;
    logic [7:0] wr_byte_q;

    // Edges; the clock is ignored while deselected, so either idle level works
    wire logic cs_fall;
    wire logic cs_rise;
    wire logic sck_rise;
    wire logic sck_fall;
    assign cs_fall = cs_p_q && !cs_s;
    assign cs_rise = !cs_p_q && cs_s;
    assign sck_rise = !sck_p_q && sck_s && !cs_s && !cs_p_q;
    assign sck_fall = sck_p_q && !sck_s && !cs_s && !cs_p_q;

    wire logic in_cmd;
    wire logic addr_take;
    wire logic addr_match;
    wire logic cmd_done;
    wire logic byte_end;
    wire logic [7:0] shift_in_d;
    wire logic [7:0] status_vec;
    wire logic [2:0] status_bit;
    assign in_cmd = (state_q == spi_cmd_pkg::ST_CMD);
    assign shift_in_d = {shift_in_q[6:0], sdi_s};
    assign addr_take = in_cmd && sck_rise && (cnt_q == spi_cmd_pkg::ADDR_DONE_CNT);
    assign addr_match = (shift_in_d[1:0] == hardwired_chip_address);
    assign cmd_done = in_cmd && sck_rise && (cnt_q == spi_cmd_pkg::CMD_DONE_CNT);
    assign byte_end = (cnt_q == spi_cmd_pkg::BYTE_LAST_CNT);
    assign fields.cmd_byte = shift_in_d;
    assign status_vec = {spi_cmd_pkg::STATUS_TOP, status_q};
    assign status_bit = 3'(spi_cmd_pkg::CMD_DONE_CNT - cnt_q);

    // Decoded actions at the last command bit
    wire logic take_quick;
    wire logic take_write;
    wire logic take_read;
    assign take_quick = cmd_done && fields.quick_valid;
    assign take_write = cmd_done && fields.is_write && fields.write_allowed;
    assign take_read = cmd_done && fields.is_read;

    // Outside a full reset, only flags shown in the latched status clear; later events wait for the next frame
    wire logic map_reset;
    wire logic dr_clear;
    wire logic crc_clear;
    assign map_reset = take_quick && fields.full_reset;
    assign dr_clear = (cmd_done && status_q[2]) || map_reset;
    assign crc_clear = (cmd_done && status_q[1]) || map_reset;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_p_q <= 1'h1;
            sck_p_q <= 1'h0;
        end else begin
            cs_p_q <= cs_s;
            sck_p_q <= sck_s;
        end
    end

    // Link sequencing; the type chosen at the last command bit holds to the frame end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= spi_cmd_pkg::ST_IDLE;
        end else if (cs_s) begin
            state_q <= spi_cmd_pkg::ST_IDLE;
        end else if (cs_fall) begin
            state_q <= spi_cmd_pkg::ST_CMD;
        end else if (addr_take && !addr_match) begin
            state_q <= spi_cmd_pkg::ST_IGNORE;
        end else if (cmd_done) begin
            case (1'b1)
                take_write: state_q <= spi_cmd_pkg::ST_WRITE;
                take_read: state_q <= spi_cmd_pkg::ST_READ;
                default: state_q <= spi_cmd_pkg::ST_IGNORE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= spi_cmd_pkg::CNT_RESET;
            shift_in_q <= spi_cmd_pkg::BYTE_RESET;
        end else if (cs_fall || cs_s) begin
            cnt_q <= spi_cmd_pkg::CNT_RESET;
            shift_in_q <= spi_cmd_pkg::BYTE_RESET;
        end else if (cmd_done) begin
            cnt_q <= spi_cmd_pkg::CNT_RESET;
            shift_in_q <= shift_in_d;
        end else if (sck_rise && (in_cmd || state_q == spi_cmd_pkg::ST_WRITE)) begin
            cnt_q <= byte_end ? spi_cmd_pkg::CNT_RESET : cnt_q + 4'h1;
            shift_in_q <= shift_in_d;
        end else if (sck_fall && state_q == spi_cmd_pkg::ST_READ) begin
            cnt_q <= byte_end ? spi_cmd_pkg::CNT_RESET : cnt_q + 4'h1;
        end
    end

    // Status is captured once the address is known to match
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= spi_cmd_pkg::STATUS_RESET;
        end else if (cs_fall) begin
            status_q <= spi_cmd_pkg::STATUS_RESET;
        end else if (addr_take && addr_match) begin
            status_q <= {hardwired_chip_address, hardwired_chip_address[0],
                         dr_q, crc_q, por_q};
        end
    end

    // Output pin: status during the command byte, read data after it, else floating
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'h0;
            sdo_q <= 1'h0;
            shift_out_q <= spi_cmd_pkg::BYTE_RESET;
        end else if (cs_s) begin
            oe_q <= 1'h0;
        end else if (cs_fall) begin
            oe_q <= 1'h1;
            sdo_q <= 1'h0;
        end else if ((addr_take && !addr_match) || (cmd_done && !take_read)) begin
            oe_q <= 1'h0;
        end else if (sck_fall && in_cmd) begin
            sdo_q <= status_vec[status_bit];
        end else if (sck_fall && state_q == spi_cmd_pkg::ST_READ) begin
            if (cnt_q == spi_cmd_pkg::CNT_RESET) begin
                sdo_q <= read_byte[7];
                shift_out_q <= {read_byte[6:0], 1'h0};
            end else begin
                sdo_q <= shift_out_q[7];
                shift_out_q <= {shift_out_q[6:0], 1'h0};
            end
        end
    end

    // Sticky flags; a new event in the clearing cycle survives
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dr_q <= spi_cmd_pkg::FLAG_RESET;
            crc_q <= spi_cmd_pkg::FLAG_RESET;
            por_q <= spi_cmd_pkg::POR_FLAG_RESET;
        end else begin
            dr_q <= (dr_q && !dr_clear) || conversion_done_event;
            crc_q <= (crc_q && !crc_clear) || config_checksum_event;
            if (map_reset) begin
                por_q <= spi_cmd_pkg::POR_FLAG_AFTER_FULL_RESET;
            end else if (cmd_done && status_q[0]) begin
                por_q <= spi_cmd_pkg::POR_FLAG_RESET;
            end
        end
    end

    // One-cycle request pulses toward the register file
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_wr_q <= 1'h0;
            mode_value_q <= spi_cmd_pkg::MODE_SHUTDOWN;
            cfg_clear_q <= 1'h0;
            full_reset_q <= 1'h0;
            rd_start_q <= 1'h0;
            rd_inc_q <= 1'h0;
            wr_start_q <= 1'h0;
            index_q <= spi_cmd_pkg::CNT_RESET;
        end else begin
            mode_wr_q <= take_quick && fields.mode_wr;
            cfg_clear_q <= take_quick && fields.config_clear;
            full_reset_q <= take_quick && fields.full_reset;
            rd_start_q <= take_read;
            wr_start_q <= take_write;
            if (take_quick && fields.mode_wr) begin
                mode_value_q <= fields.mode_value;
            end
            if (take_read || take_write) begin
                index_q <= fields.index;
                rd_inc_q <= fields.is_incremental;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_next_q <= 1'h0;
            wr_valid_q <= 1'h0;
            wr_byte_q <= spi_cmd_pkg::BYTE_RESET;
        end else begin
            rd_next_q <= sck_fall && state_q == spi_cmd_pkg::ST_READ && byte_end;
            wr_valid_q <= sck_rise && state_q == spi_cmd_pkg::ST_WRITE && byte_end;
            if (sck_rise && state_q == spi_cmd_pkg::ST_WRITE && byte_end) begin
                wr_byte_q <= shift_in_d;
            end
        end
    end

    assign sdo = sdo_q;
    assign sdo_oe = oe_q;
    assign conversion_done_flag = dr_q;
    assign config_checksum_flag = crc_q;
    assign por_flag = por_q;
    assign conv_mode_wr = mode_wr_q;
    assign conv_mode_value = mode_value_q;
    assign config_clear = cfg_clear_q;
    assign full_reset = full_reset_q;
    assign read_start = rd_start_q;
    assign read_incremental = rd_inc_q;
    assign read_next = rd_next_q;
    assign write_start = wr_start_q;
    assign reg_index = index_q;
    assign write_byte_valid = wr_valid_q;
    assign write_byte = wr_byte_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_cs_fall_drives_zero;
        cs_fall |=> sdo_oe && !sdo;
    endproperty
    a_cs_fall_drives_zero: assert property (p_cs_fall_drives_zero)
        else $error("output not driven low after select");

    property p_mismatch_floats;
        addr_take && !addr_match |=> !sdo_oe throughout (!cs_s [*4]);
    endproperty
    a_mismatch_floats: assert property (p_mismatch_floats)
        else $error("output driven after address mismatch");

    property p_status_address;
        addr_take && addr_match |=> status_q[5:4] == hardwired_chip_address &&
            status_q[3] == hardwired_chip_address[0];
    endproperty
    a_status_address: assert property (p_status_address)
        else $error("status address bits wrong");

    property p_start_mode;
        take_quick && fields.index == spi_cmd_pkg::QC_CONV_START |=>
            conv_mode_wr && conv_mode_value == spi_cmd_pkg::MODE_CONVERT ##1 !conv_mode_wr;
    endproperty
    a_start_mode: assert property (p_start_mode)
        else $error("start command did not write mode");

    property p_shutdown_mode;
        take_quick && fields.index == spi_cmd_pkg::QC_CONV_SHUTDOWN |=>
            conv_mode_wr && conv_mode_value == spi_cmd_pkg::MODE_SHUTDOWN;
    endproperty
    a_shutdown_mode: assert property (p_shutdown_mode)
        else $error("shutdown command did not write mode");

    property p_disabled_quick;
        cmd_done && fields.is_quick && !quick_command_enable |=>
            !conv_mode_wr && !config_clear && !full_reset;
    endproperty
    a_disabled_quick: assert property (p_disabled_quick)
        else $error("quick command acted while disabled");

    property p_quick_floats;
        cmd_done && fields.is_quick |=> !sdo_oe [*3];
    endproperty
    a_quick_floats: assert property (p_quick_floats)
        else $error("output driven after quick command");

    property p_read_only_write;
        cmd_done && fields.is_write && !fields.write_allowed |=>
            !write_start ##1 state_q == spi_cmd_pkg::ST_IGNORE || cs_s;
    endproperty
    a_read_only_write: assert property (p_read_only_write)
        else $error("write to read-only register started");

    property p_full_reset_por;
        full_reset |-> por_flag && $past(state_q) == spi_cmd_pkg::ST_CMD;
    endproperty
    a_full_reset_por: assert property (p_full_reset_por)
        else $error("power-on flag not set by full reset");

    property p_cs_rise_resets;
        cs_rise |=> state_q == spi_cmd_pkg::ST_IDLE && !sdo_oe;
    endproperty
    a_cs_rise_resets: assert property (p_cs_rise_resets)
        else $error("interface not reset by select rise");

    property p_flags_cleared;
        cmd_done && status_q[2] && !conversion_done_event |=> !conversion_done_flag;
    endproperty
    a_flags_cleared: assert property (p_flags_cleared)
        else $error("ready flag not cleared after status");

    c_quick_start: cover property (take_quick ##1 conv_mode_wr);
    c_full_reset: cover property (full_reset ##[1:50] por_flag);
    c_read: cover property (read_start ##[1:400] read_next);
    c_write: cover property (write_start ##[1:400] write_byte_valid);
    c_mismatch: cover property (addr_take && !addr_match);
endmodule : spi_command_byte_decoder

// *** verilog/spi_cmd_pkg.sv ***
package spi_cmd_pkg;

    // Command byte field positions
    localparam int CHIP_HI = 7;
    localparam int CHIP_LO = 6;
    localparam int IDX_HI = 5;
    localparam int IDX_LO = 2;
    localparam int OP_HI = 1;
    localparam int OP_LO = 0;

    // Bit counts within a byte
    localparam logic [3:0] ADDR_DONE_CNT = 4'h1;
    localparam logic [3:0] CMD_DONE_CNT = 4'h7;
    localparam logic [3:0] BYTE_LAST_CNT = 4'h7;
    localparam logic [3:0] CNT_RESET = 4'h0;

    // Operation types
    localparam logic [1:0] OP_QUICK = 2'h0;
    localparam logic [1:0] OP_STATIC_READ = 2'h1;
    localparam logic [1:0] OP_INC_WRITE = 2'h2;
    localparam logic [1:0] OP_INC_READ = 2'h3;

    // Quick-command codes
    localparam logic [3:0] QC_CONV_START = 4'hA;
    localparam logic [3:0] QC_STANDBY = 4'hB;
    localparam logic [3:0] QC_CONV_SHUTDOWN = 4'hC;
    localparam logic [3:0] QC_FULL_SHUTDOWN = 4'hD;
    localparam logic [3:0] QC_FULL_RESET = 4'hE;

    // Conversion mode values written by quick commands
    localparam logic [1:0] MODE_CONVERT = 2'h3;
    localparam logic [1:0] MODE_STANDBY = 2'h2;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [7:0] CONFIG_CLEAR_VALUE = 8'h00;

    // Registers that refuse writes, one bit per index
    localparam logic [15:0] READ_ONLY_MASK = 16'h8001;

    // Status byte and reset values
    localparam logic [1:0] STATUS_TOP = 2'h0;
    localparam logic FLAG_RESET = 1'h0;
    localparam logic POR_FLAG_RESET = 1'h0;
    localparam logic POR_FLAG_AFTER_FULL_RESET = 1'h1;
    localparam logic [1:0] DEFAULT_CHIP_ADDR = 2'h1;
    localparam logic [2:0] PIN_SYNC_RESET = 3'h4;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [5:0] STATUS_RESET = 6'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_WRITE,
        ST_READ,
        ST_IGNORE
    } link_state_e;

endpackage : spi_cmd_pkg

// *** verilog/cmd_fields_if.sv ***
`timescale 1ns/10ps
interface cmd_fields_if;
    logic [7:0] cmd_byte;
    logic [1:0] chip_addr;
    logic [3:0] index;
    logic is_quick;
    logic is_read;
    logic is_incremental;
    logic is_write;
    logic write_allowed;
    logic quick_valid;
    logic mode_wr;
    logic [1:0] mode_value;
    logic config_clear;
    logic full_reset;

    modport decoder (
        input cmd_byte,
        output chip_addr, index, is_quick, is_read, is_incremental, is_write,
        output write_allowed, quick_valid, mode_wr, mode_value, config_clear, full_reset
    );
    modport user (
        output cmd_byte,
        input chip_addr, index, is_quick, is_read, is_incremental, is_write,
        input write_allowed, quick_valid, mode_wr, mode_value, config_clear, full_reset
    );
endinterface : cmd_fields_if

// *** verilog/pin_sync.sv ***
`timescale 1ns/10ps
module pin_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Raw pins {cs_n, sck, sdi}
    input wire logic [2:0] pins_raw,
    // Synchronised pins
    output logic [2:0] pins_sync
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;

    // Only the second stage is visible to logic
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= spi_cmd_pkg::PIN_SYNC_RESET;
            sync_q <= spi_cmd_pkg::PIN_SYNC_RESET;
        end else begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
        end
    end

    assign pins_sync = sync_q;
endmodule : pin_sync

// *** verilog/cmd_decode.sv ***
`timescale 1ns/10ps
module cmd_decode (
    // Configuration
    input wire logic quick_command_enable,
    // Command fields
    cmd_fields_if.decoder fields
);
    wire logic [1:0] op;
    wire logic [3:0] code;

    assign op = fields.cmd_byte[spi_cmd_pkg::OP_HI:spi_cmd_pkg::OP_LO];
    assign code = fields.cmd_byte[spi_cmd_pkg::IDX_HI:spi_cmd_pkg::IDX_LO];
    assign fields.chip_addr = fields.cmd_byte[spi_cmd_pkg::CHIP_HI:spi_cmd_pkg::CHIP_LO];
    assign fields.index = code;
    assign fields.is_quick = (op == spi_cmd_pkg::OP_QUICK);
    assign fields.is_read = (op == spi_cmd_pkg::OP_STATIC_READ) ||
                            (op == spi_cmd_pkg::OP_INC_READ);
    assign fields.is_incremental = (op == spi_cmd_pkg::OP_INC_READ);
    assign fields.is_write = (op == spi_cmd_pkg::OP_INC_WRITE);
    // Any index reads back, so no read is ever refused
    assign fields.write_allowed = !spi_cmd_pkg::READ_ONLY_MASK[code];

    wire logic code_start;
    wire logic code_standby;
    wire logic code_shutdown;
    wire logic code_full_shutdown;
    wire logic code_full_reset;
    assign code_start = (code == spi_cmd_pkg::QC_CONV_START);
    assign code_standby = (code == spi_cmd_pkg::QC_STANDBY);
    assign code_shutdown = (code == spi_cmd_pkg::QC_CONV_SHUTDOWN);
    assign code_full_shutdown = (code == spi_cmd_pkg::QC_FULL_SHUTDOWN);
    assign code_full_reset = (code == spi_cmd_pkg::QC_FULL_RESET);

    // Undefined codes match none of the above and do nothing
    assign fields.quick_valid = fields.is_quick && quick_command_enable &&
        (code_start || code_standby || code_shutdown || code_full_shutdown ||
         code_full_reset);
    assign fields.mode_wr = fields.quick_valid &&
                            (code_start || code_standby || code_shutdown);
    assign fields.mode_value = code_start ? spi_cmd_pkg::MODE_CONVERT :
                               code_standby ? spi_cmd_pkg::MODE_STANDBY :
                               spi_cmd_pkg::MODE_SHUTDOWN;
    assign fields.config_clear = fields.quick_valid && code_full_shutdown;
    assign fields.full_reset = fields.quick_valid && code_full_reset;
endmodule : cmd_decode

// *** dv/spi_master_model.sv ***
`timescale 1ns/10ps
module spi_master_model (
    // Link pins
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic oe_end;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
        oe_end = 1'b0;
    end

    // Idle-low clock; sdo is read after each rise, settled and before a late float
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #40 sck = 1'b1;
            // A floating pin reads back inverted, so a stale level is never taken as data
            #20 rx[i] = sdo_oe ? sdo : ~sdo;
            #20 sck = 1'b0;
        end
    endtask : xfer

    task automatic frame(input logic [7:0] cmd, input logic two, output logic [7:0] st,
            output logic [7:0] dat);
        dat = 8'h00;
        cs_n = 1'b0;
        xfer(cmd, st);
        if (two) begin
            xfer(8'h35, dat);
        end
        #40 oe_end = sdo_oe;
        cs_n = 1'b1;
        #100;
    endtask : frame
endmodule : spi_master_model

// *** dv/spi_command_byte_decoder_bench.sv ***
`timescale 1ns/10ps
module spi_command_byte_decoder_bench;
    logic core_clk, rst_n, cs_n, sck, sdi, sdo, sdo_oe, qen, ev_dr, ev_crc;
    logic dr_f, crc_f, por_f, mode_wr, clr, frst, rd_st, rd_inc, rd_nx, wr_st, wb_v;
    logic [1:0] mode_v;
    logic [3:0] idx;
    logic [7:0] wb;
    logic [19:0] cnt;
    logic [7:0] cnt2;
    int miscompares, checks_done;

    spi_master_model u_master (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

    spi_command_byte_decoder u_dut (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
        .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .quick_command_enable(qen),
        .conversion_done_event(ev_dr), .config_checksum_event(ev_crc),
        .conversion_done_flag(dr_f), .config_checksum_flag(crc_f), .por_flag(por_f),
        .conv_mode_wr(mode_wr), .conv_mode_value(mode_v), .config_clear(clr),
        .full_reset(frst), .read_start(rd_st), .read_incremental(rd_inc), .read_next(rd_nx),
        .write_start(wr_st), .reg_index(idx), .write_byte_valid(wb_v), .write_byte(wb),
        .read_byte(8'hC6));

    // Pulse counters, four bits each: mode, clear, reset, write, read; read next, write byte
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 20'h00000;
            cnt2 <= 8'h00;
        end else begin
            cnt <= cnt + {3'h0, mode_wr, 3'h0, clr, 3'h0, frst, 3'h0, wr_st, 3'h0, rd_st};
            cnt2 <= cnt2 + {3'h0, rd_nx, 3'h0, wb_v};
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic run_cmd(input logic [7:0] cmd, input logic two, input logic [19:0] d_exp,
            input logic [7:0] st_exp, input logic [7:0] mask, input logic oe_exp);
        logic [19:0] c0;
        logic [7:0] st, dat;
        c0 = cnt;
        @(posedge core_clk);
        #1 u_master.frame(cmd, two, st, dat);
        check(cnt - c0, d_exp);
        check(st & mask, st_exp);
        check(u_master.oe_end, oe_exp);
        if (two && oe_exp) check(dat, 8'hC6);
    endtask : run_cmd

    task automatic quick_codes();
        run_cmd(8'h68, 1'b0, 20'h10000, 8'h18, 8'hFF, 1'b0);
        check(mode_v, 2'h3);
        run_cmd(8'h6C, 1'b0, 20'h10000, 8'h18, 8'hFF, 1'b0);
        check(mode_v, 2'h2);
        run_cmd(8'h70, 1'b0, 20'h10000, 8'h18, 8'hFF, 1'b0);
        check(mode_v, 2'h0);
        run_cmd(8'h74, 1'b0, 20'h01000, 8'h18, 8'hFF, 1'b0);
        run_cmd(8'h78, 1'b0, 20'h00100, 8'h18, 8'hFF, 1'b0);
        check(por_f, 1'b1);
    endtask : quick_codes

    task automatic refused_cmds();
        logic [7:0] n0;
        n0 = cnt2;
        run_cmd(8'h7C, 1'b0, 20'h00000, 8'h19, 8'hFF, 1'b0);
        run_cmd(8'h60, 1'b0, 20'h00000, 8'h18, 8'hFF, 1'b0);
        run_cmd(8'hA8, 1'b0, 20'h00000, 8'h00, 8'hC0, 1'b0);
        qen = 1'b0;
        run_cmd(8'h68, 1'b0, 20'h00000, 8'h18, 8'hFF, 1'b0);
        qen = 1'b1;
        run_cmd(8'h42, 1'b1, 20'h00000, 8'h18, 8'hFF, 1'b0);
        run_cmd(8'h7E, 1'b1, 20'h00000, 8'h18, 8'hFF, 1'b0);
        check(cnt2 - n0, 8'h00);
    endtask : refused_cmds

    task automatic flags_and_access();
        logic [7:0] n0;
        n0 = cnt2;
        @(posedge core_clk);
        #1 ev_dr = 1'b1;
        ev_crc = 1'b1;
        @(posedge core_clk);
        #1 ev_dr = 1'b0;
        ev_crc = 1'b0;
        check({dr_f, crc_f}, 2'h3);
        run_cmd(8'h49, 1'b1, 20'h00001, 8'h1E, 8'hFF, 1'b1);
        check({dr_f, crc_f, por_f}, 3'h0);
        check({idx, rd_inc}, {4'h2, 1'b0});
        run_cmd(8'h7F, 1'b1, 20'h00001, 8'h18, 8'hFF, 1'b1);
        check({idx, rd_inc}, {4'hF, 1'b1});
        run_cmd(8'h46, 1'b1, 20'h00010, 8'h18, 8'hFF, 1'b0);
        check({idx, wb}, {4'h1, 8'h35});
        check(cnt2 - n0, 8'h21);
    endtask : flags_and_access

    initial begin
        rst_n = 1'b0;
        qen = 1'b1;
        ev_dr = 1'b0;
        ev_crc = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (10) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge core_clk);
        quick_codes();
        refused_cmds();
        flags_and_access();
        stop_test();
    end

    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule : spi_command_byte_decoder_bench
